// [rtl/ums_pkg.sv]
// constants shared by the modem status, scratch and shadow receive block
// assumes a 32-bit plain register port and a byte-wide receiver outside
// What this block does
// [RULE1] The clear-to-send status bit reads as the inverse of the active-low pin and resets to 1.
// [RULE2] In loopback the clear-to-send status bit follows the request-to-send control bit.
// [RULE3] The scratch byte is an 8-bit read/write store, reset to zero, with no other effect.
// [RULE4] Sixteen consecutive word addresses all alias the receive buffer for burst reads.
// [RULE5] A shadow read returns in bits 7:0 the byte from the serial or infrared receiver.
// [RULE6] Software trusts shadow read data only while the data-ready flag is set.
// [RULE7] With FIFOs off, a new byte overwrites an unread one and raises overrun.
// [RULE8] With FIFOs on, a shadow read returns the FIFO head and pops it.
// [RULE9] With FIFOs on, a byte arriving at a full FIFO is dropped and raises overrun; the code takes it without overrun when a window read pops the same cycle.
// [RULE10] Data ready clears on a buffer read without FIFOs, or when the FIFO empties.
// [RULE11] Reserved bits read as zero and writes to them are ignored.
package ums_pkg;
   localparam int ADDR_W = 32;
   localparam int DATA_W = 32;
   localparam int BYTE_W = 8;
   localparam int FIFO_DEPTH = 16;
   localparam int PTR_W = 4;
   localparam int CNT_W = 5;
   localparam logic [CNT_W-1:0] FIFO_FULL_COUNT = 5'h10;
   localparam logic [ADDR_W-1:0] MODEM_STATUS_ADDR = 32'h50001018;
   localparam logic [ADDR_W-1:0] SCRATCH_ADDR = 32'h5000101C;
   localparam logic [ADDR_W-1:0] WINDOW_FIRST_ADDR = 32'h50001030;
   localparam logic [ADDR_W-1:0] WINDOW_LAST_ADDR = 32'h5000106C;
   localparam logic [ADDR_W-1:0] WORD_ALIGN_MASK = 32'h00000003;
   localparam int CTS_BIT = 4;
   localparam logic CTS_RESET = 1'h1;
   localparam logic CTS_SYNC_RESET = 1'h0;
   localparam logic [BYTE_W-1:0] SCRATCH_RESET = 8'h00;
   localparam logic [BYTE_W-1:0] BYTE_RESET = 8'h00;
   localparam logic [DATA_W-1:0] READ_IDLE = 32'h00000000;
endpackage : ums_pkg

// [rtl/ums_rx_if.sv]
// receive FIFO carrier between the register block and its FIFO
// assumes both ends share one clock
interface ums_rx_if;
   logic push;
   logic [ums_pkg::BYTE_W-1:0] pushData;
   logic pop;
   logic flush;
   logic [ums_pkg::BYTE_W-1:0] head;
   logic empty;
   logic full;
   logic [ums_pkg::CNT_W-1:0] count;
   modport fifo (input push, pushData, pop, flush, output head, empty, full, count);
   modport user (output push, pushData, pop, flush, input head, empty, full, count);
endinterface : ums_rx_if

// [rtl/ums_rx_fifo.sv]
// receive FIFO, sixteen bytes, head shown combinationally
// assumes the user pops only when not empty; a push at full is dropped unless a pop frees a slot the same cycle
module ums_rx_fifo (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // fifo port
   ums_rx_if.fifo rx
);
   logic [ums_pkg::BYTE_W-1:0] mem [ums_pkg::FIFO_DEPTH];
   logic [ums_pkg::PTR_W-1:0] wrPtr, next_wrPtr, rdPtr, next_rdPtr;
   logic [ums_pkg::CNT_W-1:0] count, next_count;
   logic doPush, doPop;

   // widens a one-bit step to pointer width
   function automatic logic [ums_pkg::PTR_W-1:0] PTR_W_ONE(input logic step);
      PTR_W_ONE = {3'h0, step};
   endfunction

   // a full fifo takes a byte only when a pop frees a slot the same cycle
   always_comb begin
      doPop = rx.pop && (count != '0) && !rx.flush;
      doPush = rx.push && !rx.flush && ((count != ums_pkg::FIFO_FULL_COUNT) || doPop); // [RULE9]
      next_wrPtr = rx.flush ? '0 : wrPtr + PTR_W_ONE(doPush);
      next_rdPtr = rx.flush ? '0 : rdPtr + PTR_W_ONE(doPop); // [RULE8]
      next_count = rx.flush ? '0 : count + {4'h0, doPush} - {4'h0, doPop};
   end

   // pointer and count registers
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
      end else begin
         wrPtr <= next_wrPtr;
         rdPtr <= next_rdPtr;
         count <= next_count;
      end
   end

   // storage, written only on an accepted push
   always_ff @(posedge clock) begin
      if (doPush) begin
         mem[wrPtr] <= rx.pushData;
      end
   end

   assign rx.head = mem[rdPtr];
   assign rx.empty = (count == '0);
   assign rx.full = (count == ums_pkg::FIFO_FULL_COUNT);
   assign rx.count = count;

   fullKeep_a: assert property (@(posedge clock) disable iff (reset) // [RULE9]
      (rx.full && rx.push && !rx.pop && !rx.flush) |=> (count == $past(count) && rdPtr == $past(rdPtr)))
      else $error("push at full fifo changed its contents");
   popStep_a: assert property (@(posedge clock) disable iff (reset) // [RULE8]
      (rx.pop && !rx.empty && !rx.push && !rx.flush) |=> (count == $past(count) - 5'h01))
      else $error("pop did not remove the head entry");
endmodule // ums_rx_fifo

// [rtl/ums_regs.sv]
// modem status, scratch byte and shadow receive window of the uart
// assumes control bits and received bytes come from logic on the same clock;
// only the clear-to-send pin is asynchronous
//
// The address-and-strobe port was decided locally.
module ums_regs (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // register port
   input wire logic [ums_pkg::ADDR_W-1:0] address,
   input wire logic [ums_pkg::DATA_W-1:0] writeData,
   input wire logic writeStrobe,
   input wire logic readStrobe,
   output logic [ums_pkg::DATA_W-1:0] readData,
   // modem line and control bits
   input wire logic ctsN,
   input wire logic loopbackEnable,
   input wire logic requestToSend,
   input wire logic fifoEnable,
   // receivers
   input wire logic irMode,
   input wire logic uartRxValid,
   input wire logic [ums_pkg::BYTE_W-1:0] uartRxByte,
   input wire logic irRxValid,
   input wire logic [ums_pkg::BYTE_W-1:0] irRxByte,
   // line status feeds
   output logic rxDataAvailable,
   output logic overrunPulse
);
   ums_rx_if rx ();

   logic ctsMeta, ctsSync, ctsStatus, next_ctsStatus;
   logic [ums_pkg::BYTE_W-1:0] scratch, next_scratch, holdByte, next_holdByte;
   logic holdFull, next_holdFull, next_overrun, next_dataReady;
   logic [ums_pkg::DATA_W-1:0] next_readData;
   logic msrHit, scrHit, winHit, winRead, rxValid;
   logic [ums_pkg::BYTE_W-1:0] rxByte;

   ums_rx_fifo rxFifo (
      .clock(clock),
      .reset(reset),
      .rx(rx)
   );

   // two-flop synchroniser for the pin
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         ctsMeta <= ums_pkg::CTS_SYNC_RESET;
         ctsSync <= ums_pkg::CTS_SYNC_RESET;
      end else begin
         ctsMeta <= ctsN;
         ctsSync <= ctsMeta;
      end
   end

   // address decode and receiver select
   always_comb begin
      msrHit = (address == ums_pkg::MODEM_STATUS_ADDR);
      scrHit = (address == ums_pkg::SCRATCH_ADDR);
      winHit = (address >= ums_pkg::WINDOW_FIRST_ADDR) // [RULE4]
         && (address <= ums_pkg::WINDOW_LAST_ADDR)
         && ((address & ums_pkg::WORD_ALIGN_MASK) == '0);
      winRead = readStrobe && winHit;
      rxValid = irMode ? irRxValid : uartRxValid; // [RULE5]
      rxByte = irMode ? irRxByte : uartRxByte; // [RULE5]
   end

   // fifo control: the fifo is held empty while fifos are off
   always_comb begin
      rx.push = fifoEnable && rxValid;
      rx.pushData = rxByte;
      rx.pop = fifoEnable && winRead && !rx.empty; // [RULE8]
      rx.flush = !fifoEnable;
   end

   // next values of status, scratch, holding buffer and read data
   always_comb begin
      next_ctsStatus = loopbackEnable ? requestToSend : !ctsSync; // [RULE1] [RULE2]
      next_scratch = scratch;
      if (writeStrobe && scrHit) begin
         next_scratch = writeData[ums_pkg::BYTE_W-1:0]; // [RULE3] [RULE11]
      end
      next_holdByte = holdByte;
      next_holdFull = holdFull;
      if (!fifoEnable) begin
         if (winRead) begin
            next_holdFull = 1'b0; // [RULE10]
         end
         if (rxValid) begin
            next_holdByte = rxByte; // [RULE7]
            next_holdFull = 1'b1; // arrival wins over a same-cycle read
         end
      end else begin
         next_holdFull = 1'b0;
      end
      next_overrun = rxValid && (fifoEnable ? (rx.full && !rx.pop) // [RULE9]
         : (holdFull && !winRead)); // [RULE7]
      next_dataReady = fifoEnable ? !rx.empty : holdFull; // [RULE10]
      next_readData = ums_pkg::READ_IDLE;
      if (readStrobe) begin
         if (msrHit) begin
            next_readData[ums_pkg::CTS_BIT] = ctsStatus; // [RULE11]
         end else if (scrHit) begin
            next_readData[ums_pkg::BYTE_W-1:0] = scratch;
         end else if (winHit) begin
            next_readData[ums_pkg::BYTE_W-1:0] = fifoEnable ? rx.head : holdByte; // [RULE8]
         end
      end
   end

   // state and output registers
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         ctsStatus <= ums_pkg::CTS_RESET;
         scratch <= ums_pkg::SCRATCH_RESET;
         holdByte <= ums_pkg::BYTE_RESET;
         holdFull <= 1'b0;
         overrunPulse <= 1'b0;
         rxDataAvailable <= 1'b0;
         readData <= ums_pkg::READ_IDLE;
      end else begin
         ctsStatus <= next_ctsStatus;
         scratch <= next_scratch;
         holdByte <= next_holdByte;
         holdFull <= next_holdFull;
         overrunPulse <= next_overrun;
         rxDataAvailable <= next_dataReady;
         readData <= next_readData;
      end
   end

   // helper: cycles since reset release, saturating at three
   logic [1:0] warm;
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         warm <= 2'h0;
      end else if (warm != 2'h3) begin
         warm <= warm + 2'h1;
      end
   end

   ctsInvert_a: assert property (@(posedge clock) disable iff (reset) // [RULE1]
      (warm == 2'h3 && $past(!loopbackEnable)) |-> (ctsStatus == !$past(ctsN, 3)))
      else $error("clear-to-send status is not the inverted pin");
   ctsLoop_a: assert property (@(posedge clock) disable iff (reset) // [RULE2]
      loopbackEnable ##1 (readStrobe && msrHit) |=> readData[ums_pkg::CTS_BIT] == $past(requestToSend, 2))
      else $error("loopback status does not follow request-to-send");
   scratchStore_a: assert property (@(posedge clock) disable iff (reset) // [RULE3]
      (writeStrobe && scrHit) ##1 (readStrobe && scrHit)
      |=> readData == {24'h000000, $past(writeData[ums_pkg::BYTE_W-1:0], 2)})
      else $error("scratch byte did not hold the written value");
   windowAlias_a: assert property (@(posedge clock) disable iff (reset) // [RULE4]
      (readStrobe && !fifoEnable && address == ums_pkg::WINDOW_LAST_ADDR)
      |=> readData == {24'h000000, $past(holdByte)})
      else $error("last window word is not an alias of the buffer");
   irSelect_a: assert property (@(posedge clock) disable iff (reset) // [RULE5]
      (!fifoEnable && irMode && irRxValid) |=> (holdByte == $past(irRxByte) && holdFull))
      else $error("infrared byte not captured");
   overwrite_a: assert property (@(posedge clock) disable iff (reset) // [RULE7]
      (!fifoEnable && holdFull && rxValid && !winRead) |=> (overrunPulse && holdByte == $past(rxByte)))
      else $error("overwrite without overrun");
   fifoHead_a: assert property (@(posedge clock) disable iff (reset) // [RULE8]
      (fifoEnable && winRead && !rx.empty) |=> readData[ums_pkg::BYTE_W-1:0] == $past(rx.head))
      else $error("window read did not return fifo head");
   fullDrop_a: assert property (@(posedge clock) disable iff (reset) // [RULE9]
      (fifoEnable && rx.full && rxValid && !winRead) |=> (overrunPulse && rx.full))
      else $error("byte at full fifo did not raise overrun");
   readyClear_a: assert property (@(posedge clock) disable iff (reset) // [RULE10]
      (!fifoEnable && winRead && !rxValid) ##1 (!fifoEnable && !rxValid) |=> !rxDataAvailable)
      else $error("data ready stayed set after buffer read");
   reservedZero_a: assert property (@(posedge clock) disable iff (reset) // [RULE11]
      $past(readStrobe && msrHit) |-> (readData & ~(32'h00000001 << ums_pkg::CTS_BIT)) == '0)
      else $error("reserved modem status bits not zero");

   // status bit just after reset and while loopback is on
   ctsReset_a: assert property (@(posedge clock) disable iff (reset) // [RULE1]
      (warm != 2'h3 && !$past(loopbackEnable)) |-> ctsStatus)
      else $error("clear-to-send status left its reset value too early");
   loopFollow_a: assert property (@(posedge clock) disable iff (reset) // [RULE2]
      (warm != 2'h0 && $past(loopbackEnable)) |-> (ctsStatus == $past(requestToSend)))
      else $error("loopback status is not the request-to-send bit");

   // scratch byte holds still unless written, and reads back in full
   scratchKeep_a: assert property (@(posedge clock) disable iff (reset) // [RULE3]
      !(writeStrobe && scrHit) |=> $stable(scratch))
      else $error("scratch byte changed without a write");
   scratchRead_a: assert property (@(posedge clock) disable iff (reset) // [RULE3]
      (readStrobe && scrHit) |=> (readData == {24'h000000, $past(scratch)}))
      else $error("scratch read did not return the stored byte");

   // receive buffer, overrun pulse, data ready and idle read data
   irIgnore_a: assert property (@(posedge clock) disable iff (reset) // [RULE5]
      (!fifoEnable && irMode && !irRxValid && !holdFull) |=> !holdFull)
      else $error("serial byte taken while infrared selected");
   bufferKeep_a: assert property (@(posedge clock) disable iff (reset) // [RULE7]
      !rxValid |=> $stable(holdByte))
      else $error("receive buffer changed with no arrival");
   overrunQuiet_a: assert property (@(posedge clock) disable iff (reset) // [RULE7]
      !rxValid |=> !overrunPulse)
      else $error("overrun raised with no arrival");
   popNoOverrun_a: assert property (@(posedge clock) disable iff (reset) // [RULE9]
      (fifoEnable && rxValid && rx.pop) |=> !overrunPulse)
      else $error("overrun raised although a pop freed a slot");
   readyFifo_a: assert property (@(posedge clock) disable iff (reset) // [RULE10]
      $past(fifoEnable && rx.empty) |-> !rxDataAvailable)
      else $error("data ready set with an empty fifo");
   winWrite_a: assert property (@(posedge clock) disable iff (reset) // [RULE11]
      (writeStrobe && winHit && !fifoEnable && !rxValid) |=> $stable({holdFull, holdByte}))
      else $error("write to the receive window changed the buffer");
   readIdle_a: assert property (@(posedge clock) disable iff (reset) // [RULE11]
      !$past(readStrobe) |-> (readData == ums_pkg::READ_IDLE))
      else $error("read data not zero outside a read answer");

   // main scenarios reached by the bench
   fifoOverrun_c: cover property (@(posedge clock) disable iff (reset)
      fifoEnable && rx.full && rxValid);
   burstRead_c: cover property (@(posedge clock) disable iff (reset)
      winRead [*4]);
   loopCts_c: cover property (@(posedge clock) disable iff (reset)
      loopbackEnable && requestToSend && !ctsStatus ##1 ctsStatus);
   bufferOverwrite_c: cover property (@(posedge clock) disable iff (reset)
      !fifoEnable && holdFull && rxValid && !winRead);
   fifoDrained_c: cover property (@(posedge clock) disable iff (reset)
      fifoEnable && $fell(rxDataAvailable));
endmodule // ums_regs

// [sim/ums_modem_model.sv]
// far-side model: clear-to-send pin and the serial and infrared receivers
// assumes the bench calls its tasks from a process on the same clock
module ums_modem_model (
   // clock
   input wire logic clock,
   // modem pin and receivers
   output logic ctsN,
   output logic uartRxValid,
   output logic [ums_pkg::BYTE_W-1:0] uartRxByte,
   output logic irRxValid,
   output logic [ums_pkg::BYTE_W-1:0] irRxByte
);
   timeunit 1ns;
   timeprecision 1ns;

   // pin asserted at start, byte lines idle
   initial begin
      ctsN = 1'b0;
      uartRxValid = 1'b0;
      irRxValid = 1'b0;
      uartRxByte = 8'h00;
      irRxByte = 8'h00;
   end

   // one byte, valid for one cycle; the byte lines show the inverse after it
   task automatic send(input logic [ums_pkg::BYTE_W-1:0] b, input logic ir);
      @(posedge clock);
      if (ir) begin
         irRxValid <= 1'b1;
         irRxByte <= b;
      end else begin
         uartRxValid <= 1'b1;
         uartRxByte <= b;
      end
      @(posedge clock);
      irRxValid <= 1'b0;
      uartRxValid <= 1'b0;
      irRxByte <= ~b;
      uartRxByte <= ~b;
   endtask

   // pin level change, applied nonblocking at a rising clock edge
   task automatic setCts(input logic level);
      @(posedge clock);
      ctsN <= level;
   endtask
endmodule // ums_modem_model

// [sim/ums_regs_tb.sv]
// bench for the modem status, scratch and shadow receive block
// assumes the receive FIFO sits inside ums_regs; drives by register-port tasks
module ums_regs_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock, reset, writeStrobe, readStrobe, loopbackEnable, requestToSend, fifoEnable, irMode;
   logic [ums_pkg::ADDR_W-1:0] address;
   logic [ums_pkg::DATA_W-1:0] writeData, readData;
   logic ctsN, uartRxValid, irRxValid, rxDataAvailable, overrunPulse;
   logic [ums_pkg::BYTE_W-1:0] uartRxByte, irRxByte;
   int err_total, n_tests, ovr, cyc;

   ums_regs u_dut (.clock(clock), .reset(reset), .address(address), .writeData(writeData),
      .writeStrobe(writeStrobe), .readStrobe(readStrobe), .readData(readData), .ctsN(ctsN),
      .loopbackEnable(loopbackEnable), .requestToSend(requestToSend), .fifoEnable(fifoEnable),
      .irMode(irMode), .uartRxValid(uartRxValid), .uartRxByte(uartRxByte),
      .irRxValid(irRxValid), .irRxByte(irRxByte), .rxDataAvailable(rxDataAvailable),
      .overrunPulse(overrunPulse));
   ums_modem_model u_modem (.clock(clock), .ctsN(ctsN), .uartRxValid(uartRxValid),
      .uartRxByte(uartRxByte), .irRxValid(irRxValid), .irRxByte(irRxByte));

   // 100 ns clock
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   // overrun pulse counter and hang limit
   always @(posedge clock) begin
      if (overrunPulse === 1'b1) ovr++;
      cyc++;
      if (cyc == 3000) begin
         err_total++;
         complete_run();
      end
   end

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         $display("unexpected %s expected %h seen %h", nm, e, g);
         err_total++;
      end
   endtask

   // one-cycle read, data checked in the cycle after the strobe
   task automatic rd(input logic [31:0] a, input logic [31:0] e);
      @(posedge clock);
      readStrobe <= 1'b1;
      address <= a;
      @(posedge clock);
      readStrobe <= 1'b0;
      #1 chk("readData", e, readData);
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge clock);
      writeStrobe <= 1'b1;
      address <= a;
      writeData <= d;
      @(posedge clock);
      writeStrobe <= 1'b0;
   endtask

   // write then read back in the next cycle, no gap between the strobes
   task automatic wrRd(input logic [31:0] a, input logic [31:0] d, input logic [31:0] e);
      @(posedge clock);
      writeStrobe <= 1'b1;
      address <= a;
      writeData <= d;
      @(posedge clock);
      writeStrobe <= 1'b0;
      readStrobe <= 1'b1;
      @(posedge clock);
      readStrobe <= 1'b0;
      #1 chk("readData", e, readData);
   endtask

   // four back-to-back window reads, each beat checked in the cycle after its strobe
   task automatic rdBurst(input logic [31:0] a, input logic [7:0] first);
      @(posedge clock);
      readStrobe <= 1'b1;
      address <= a;
      for (int k = 0; k < 4; k++) begin
         @(posedge clock);
         if (k < 3) address <= a + 32'(4 * (k + 1));
         else readStrobe <= 1'b0;
         #1 chk("readData", 32'(first + 8'(k)), readData);
         chk("rxDataAvailable", 32'h1, 32'(rxDataAvailable));
      end
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   task automatic complete_run;
      $display("mismatches %0d comparisons %0d", err_total, n_tests);
      if (err_total == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // main sequence
   initial begin
      reset = 1'b1;
      {writeStrobe, readStrobe, loopbackEnable, requestToSend, fifoEnable, irMode} = 6'h00;
      address = 32'h00000000;
      writeData = 32'h00000000;
      repeat (10) @(posedge clock);
      reset <= 1'b0;
      rd(ums_pkg::MODEM_STATUS_ADDR, 32'h00000010);
      rd(ums_pkg::SCRATCH_ADDR, 32'h00000000);
      rd(32'h50001020, 32'h00000000);
      wrRd(ums_pkg::SCRATCH_ADDR, 32'hFFFFFFA5, 32'h000000A5);
      wr(ums_pkg::MODEM_STATUS_ADDR, 32'hFFFFFFFF);
      rd(ums_pkg::MODEM_STATUS_ADDR, 32'h00000010);
      u_modem.setCts(1'b1);
      settle(4);
      rd(ums_pkg::MODEM_STATUS_ADDR, 32'h00000000);
      @(posedge clock);
      loopbackEnable <= 1'b1;
      requestToSend <= 1'b1;
      settle(2);
      rd(ums_pkg::MODEM_STATUS_ADDR, 32'h00000010);
      u_modem.setCts(1'b0);
      requestToSend <= 1'b0;
      settle(4);
      rd(ums_pkg::MODEM_STATUS_ADDR, 32'h00000000);
      @(posedge clock);
      loopbackEnable <= 1'b0;
      // unread byte overwritten by the next one
      u_modem.send(8'h3C, 1'b0);
      settle(3);
      chk("rxDataAvailable", 32'h1, 32'(rxDataAvailable));
      u_modem.send(8'h5A, 1'b0);
      settle(2);
      chk("overruns", 32'h1, ovr);
      wr(ums_pkg::WINDOW_FIRST_ADDR + 32'h00000004, 32'h000000FF);
      rd(ums_pkg::WINDOW_FIRST_ADDR, 32'h0000005A);
      settle(2);
      chk("rxDataAvailable", 32'h0, 32'(rxDataAvailable));
      // infrared path selected, serial byte ignored
      @(posedge clock);
      irMode <= 1'b1;
      u_modem.send(8'h11, 1'b0);
      u_modem.send(8'hC3, 1'b1);
      settle(3);
      chk("overruns", 32'h1, ovr);
      rd(ums_pkg::WINDOW_LAST_ADDR, 32'h000000C3);
      // fill the FIFO past full, then drain in bursts through every alias
      @(posedge clock);
      irMode <= 1'b0;
      fifoEnable <= 1'b1;
      settle(2);
      for (int i = 0; i <= ums_pkg::FIFO_DEPTH; i++) begin
         u_modem.send(8'(8'h40 + i), 1'b0);
      end
      settle(3);
      chk("overruns", 32'h2, ovr);
      for (int i = 0; i < 4; i++) begin
         rdBurst(ums_pkg::WINDOW_FIRST_ADDR + 32'(16 * i), 8'(8'h40 + 4 * i));
      end
      settle(2);
      chk("rxDataAvailable", 32'h0, 32'(rxDataAvailable));
      rd(ums_pkg::SCRATCH_ADDR, 32'h000000A5);
      complete_run();
   end
endmodule // ums_regs_tb
